// ### include/pfc_defines.svh
// Purpose: offsets, field positions, codes and reset values of the timer
// Assumes: byte addresses on an AXI4-Lite bus with 32-bit data
// Notes:   definitions only
`ifndef PFC_DEFINES_SVH
`define PFC_DEFINES_SVH

`define PFC_OFS_CTRL     8'h00
`define PFC_OFS_COUNT    8'h04
`define PFC_OFS_CMPA     8'h08
`define PFC_OFS_CMPB     8'h0C
`define PFC_OFS_CAPTOP   8'h10
`define PFC_OFS_STATUS   8'h14
`define PFC_OFS_MASK     8'h18
`define PFC_OFS_PINS     8'h1C

`define PFC_CTRL_MODE    0
`define PFC_CTRL_ACTA    4
`define PFC_CTRL_ACTB    6
`define PFC_CTRL_CSEL    8
`define PFC_CTRL_DDR     11

`define PFC_ST_OVF       0
`define PFC_ST_CMPA      1
`define PFC_ST_CMPB      2
`define PFC_ST_CAP       3

`define PFC_MODE_ICR     4'h8
`define PFC_MODE_OCRA    4'h9
`define PFC_MODE_PC_OCRA 4'hB

`define PFC_ACT_OFF      2'h0
`define PFC_ACT_TOGGLE   2'h1
`define PFC_ACT_NONINV   2'h2
`define PFC_ACT_INV      2'h3

`define PFC_CSEL_STOP    3'h0
`define PFC_CSEL_DIV1    3'h1
`define PFC_CSEL_DIV8    3'h2
`define PFC_CSEL_DIV64   3'h3
`define PFC_CSEL_DIV256  3'h4
`define PFC_CSEL_DIV1024 3'h5
`define PFC_MASK_DIV8    10'h007
`define PFC_MASK_DIV64   10'h03F
`define PFC_MASK_DIV256  10'h0FF
`define PFC_MASK_DIV1024 10'h3FF

`define PFC_BOTTOM       16'h0000
`define PFC_RESP_OKAY    2'h0
`define PFC_RESP_SLVERR  2'h2
`define PFC_RST_STATE    '0

`endif

// ### include/pfc_pkg.sv
// Purpose: types shared by the timer and its prescaler
// Assumes: widths fixed at the documented values
// Notes:   enum members first, so an all-zero reset means idle
package pfc_pkg;

   typedef enum logic {PFC_WR_COLLECT, PFC_WR_RESP} pfc_wr_t;
   typedef enum logic {PFC_RD_IDLE, PFC_RD_RESP}    pfc_rd_t;

   typedef struct packed {
      logic [15:0]      cnt;
      logic             dn;
      logic [1:0][15:0] ocr;
      logic [1:0][15:0] cbuf;
      logic [15:0]      icr;
      logic [3:0]       mode;
      logic [1:0][1:0]  act;
      logic [2:0]       csel;
      logic [1:0]       ddr;
      logic [1:0]       oc;
      logic [1:0]       oe;
      logic [3:0]       sts;
      logic [3:0]       msk;
      logic             irq;
      pfc_wr_t          wst;
      logic             aw_got;
      logic             w_got;
      logic [7:0]       waddr;
      logic [31:0]      wdata;
      logic [3:0]       wstrb;
      logic             awready;
      logic             wready;
      logic             bvalid;
      logic [1:0]       bresp;
      pfc_rd_t          rst;
      logic             arready;
      logic             rvalid;
      logic [31:0]      rdata;
      logic [1:0]       rresp;
   } pfc_state_t;

   typedef struct packed {
      logic [9:0] cnt;
      logic       tick;
   } pfc_pre_t;

endpackage : pfc_pkg

// ### include/pfc_tick_if.sv
// Purpose: clock select to the prescaler, timer tick back
// Assumes: both ends on aclk
// Notes:   tick is a one-cycle enable pulse
`timescale 1ns/1ps
interface pfc_tick_if;
   logic [2:0] csel;
   logic       tick;
   modport tmr (output csel, input tick);
   modport pre (input csel, output tick);
endinterface : pfc_tick_if

// ### hdl/pfc_prescaler.sv
// Purpose: divides aclk into the timer tick enable
// Assumes: csel codes stop, 1, 8, 64, 256, 1024
// Notes:   divider clears while stopped so a restart is aligned
`timescale 1ns/1ps
module pfc_prescaler
   import pfc_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   pfc_tick_if.pre   tk
);
`include "pfc_defines.svh"

   pfc_pre_t q;
   pfc_pre_t d;

   always_comb begin
      d     = q;
      d.cnt = q.cnt + 10'h001;
      case (tk.csel)
         `PFC_CSEL_DIV1:    d.tick = 1'b1;
         `PFC_CSEL_DIV8:
            d.tick = ((q.cnt & `PFC_MASK_DIV8) == `PFC_MASK_DIV8);
         `PFC_CSEL_DIV64:
            d.tick = ((q.cnt & `PFC_MASK_DIV64) == `PFC_MASK_DIV64);
         `PFC_CSEL_DIV256:
            d.tick = ((q.cnt & `PFC_MASK_DIV256) == `PFC_MASK_DIV256);
         `PFC_CSEL_DIV1024: d.tick = (q.cnt == `PFC_MASK_DIV1024);
         default: begin
            d.tick = 1'b0;
            d.cnt  = 10'h000;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= `PFC_RST_STATE;
      end else begin
         q <= d;
      end
   end

   assign tk.tick = q.tick;

endmodule : pfc_prescaler

// ### hdl/pfc_timer.sv
// Purpose: dual-slope phase and frequency correct 16-bit PWM timer
// Assumes: aclk 125 MHz, synchronous active-low reset, AXI4-Lite slave
// Notes:   counter runs only in modes 8 and 9; other modes freeze it
//
// What this block does
// - Modes 8 and 9 count 0 up to top, then back down to 0.
// - Non-inverting clears on up-count match, sets on down; inverting opposite.
// - Top is capture-top in mode 8, channel A compare in 9; reverse there.
// - Counter stays at top for exactly one tick before descending.
// - Compare flag sets on a mode 8 or 9 tick where counter equals the active compare value.
// - Compare buffers load at bottom; overflow flag sets in that tick.
// - At top, mode 9 sets channel A flag, mode 8 the capture flag.
// - Top must cover every compare; a compare above top never matches.
// - Action two gives non-inverted PWM, action three inverted PWM.
// - Compare at bottom holds low, at top holds high; inverted opposite.
// - Mode 9 with channel A action 1 toggles A each match, 50% duty.
// - Counter advances only on prescaler ticks of 1, 8, 64, 256, 1024.
// - Period is twice prescale times top in system clock cycles.
// - Action 1 toggles only channel A, and only in mode 9; outside modes 9 and 11 it disconnects.
// - Actions two and three hand the pin to the compare output; action 1 does only for A in modes 9 and 11.
//
// The register addresses and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
module pfc_timer
   import pfc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             channel_a_output_pin,
   output logic             channel_a_output_pin_oe,
   output logic             channel_b_output_pin,
   output logic             channel_b_output_pin_oe,
   output logic             irq
);
`include "pfc_defines.svh"

   pfc_state_t  q;
   pfc_state_t  d;
   pfc_tick_if  tk ();

   logic        aw_hs;
   logic        w_hs;
   logic        ar_hs;
   logic        pfc_mode;
   logic        timer_tick;
   logic [15:0] top;
   logic        up_ph;
   logic [3:0]  st_set;
   logic [3:0]  st_clr;
   logic        do_wr;
   logic [32:0] wr_old;
   logic [32:0] rd_hit;
   logic [31:0] wv;

   pfc_prescaler u_pre (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tk      (tk)
   );

   assign tk.csel    = q.csel;
   assign timer_tick = tk.tick;

   // Register image at an offset; bit 32 marks a mapped address
   function automatic logic [32:0] reg_read(input pfc_state_t s,
                                            input logic [7:0] a);
      logic [31:0] v;
      logic        hit;
      v   = 32'h0000_0000;
      hit = 1'b1;
      if (a == `PFC_OFS_CTRL) begin
         v[`PFC_CTRL_MODE +: 4] = s.mode;
         v[`PFC_CTRL_ACTA +: 2] = s.act[0];
         v[`PFC_CTRL_ACTB +: 2] = s.act[1];
         v[`PFC_CTRL_CSEL +: 3] = s.csel;
         v[`PFC_CTRL_DDR  +: 2] = s.ddr;
      end else if (a == `PFC_OFS_COUNT) begin
         v[15:0] = s.cnt;
      end else if (a == `PFC_OFS_CMPA) begin
         v[15:0] = s.cbuf[0];
      end else if (a == `PFC_OFS_CMPB) begin
         v[15:0] = s.cbuf[1];
      end else if (a == `PFC_OFS_CAPTOP) begin
         v[15:0] = s.icr;
      end else if (a == `PFC_OFS_STATUS) begin
         v[3:0] = s.sts;
      end else if (a == `PFC_OFS_MASK) begin
         v[3:0] = s.msk;
      end else if (a == `PFC_OFS_PINS) begin
         v[1:0] = s.oc;
         v[2]   = s.dn;
      end else begin
         hit = 1'b0;
      end
      return {hit, v};
   endfunction : reg_read

   // Byte-lane merge so partial writes keep untouched lanes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction : merge

   always_comb begin
      d      = q;
      st_set = 4'h0;
      st_clr = 4'h0;
      do_wr  = 1'b0;
      aw_hs  = s_axi_awvalid & q.awready;
      w_hs   = s_axi_wvalid & q.wready;
      ar_hs  = s_axi_arvalid & q.arready;
      wr_old = reg_read(q, q.waddr);
      rd_hit = reg_read(q, s_axi_araddr);
      wv     = merge(wr_old[31:0], q.wdata, q.wstrb);

      pfc_mode = (q.mode == `PFC_MODE_ICR) ||
                 (q.mode == `PFC_MODE_OCRA);
      top = (q.mode == `PFC_MODE_ICR) ? q.icr : q.ocr[0];
      // Bottom counts as rising, top as falling: this gives the
      // steady low and high levels at the compare extremes
      up_ph = (q.cnt == `PFC_BOTTOM) ||
              (!q.dn && (q.cnt != top));

      if (pfc_mode && timer_tick) begin
         for (int ch = 0; ch < 2; ch++) begin
            // Counter never exceeds top, so a higher compare is dead
            if (q.cnt == q.ocr[ch]) begin
               st_set[`PFC_ST_CMPA + ch] = 1'b1;
               case (q.act[ch])
                  `PFC_ACT_NONINV: d.oc[ch] = !up_ph;
                  `PFC_ACT_INV:    d.oc[ch] = up_ph;
                  `PFC_ACT_TOGGLE: begin
                     if (ch == 0 && q.mode == `PFC_MODE_OCRA) begin
                        d.oc[ch] = !q.oc[ch];
                     end
                  end
                  default: d.oc[ch] = q.oc[ch];
               endcase
            end
         end

         if (q.cnt == `PFC_BOTTOM) begin
            d.ocr           = q.cbuf;
            st_set[`PFC_ST_OVF] = 1'b1;
         end

         // Each value, top included, lasts one tick: period 2*N*top
         // Bottom first: on the reload tick top may still be a stale value
         if (q.cnt == `PFC_BOTTOM) begin
            d.cnt = q.cnt + 16'h0001;
            d.dn  = 1'b0;
         end else if (q.cnt == top) begin
            d.cnt = q.cnt - 16'h0001;
            d.dn  = 1'b1;
            if (q.mode == `PFC_MODE_OCRA) begin
               st_set[`PFC_ST_CMPA] = 1'b1;
            end else begin
               st_set[`PFC_ST_CAP] = 1'b1;
            end
         end else if (!q.dn) begin
            d.cnt = q.cnt + 16'h0001;
         end else begin
            d.cnt = q.cnt - 16'h0001;
         end
      end

      case (q.wst)
         PFC_WR_COLLECT: begin
            if (aw_hs) begin
               d.aw_got = 1'b1;
               d.waddr  = s_axi_awaddr;
            end
            if (w_hs) begin
               d.w_got = 1'b1;
               d.wdata = s_axi_wdata;
               d.wstrb = s_axi_wstrb;
            end
            if (q.aw_got && q.w_got) begin
               do_wr    = 1'b1;
               d.wst    = PFC_WR_RESP;
               d.bvalid = 1'b1;
               d.bresp  = wr_old[32] ? `PFC_RESP_OKAY : `PFC_RESP_SLVERR;
            end
         end
         PFC_WR_RESP: begin
            if (s_axi_bready) begin
               d.bvalid = 1'b0;
               d.aw_got = 1'b0;
               d.w_got  = 1'b0;
               d.wst    = PFC_WR_COLLECT;
            end
         end
         default: d.wst = PFC_WR_COLLECT;
      endcase

      // Software writes land after the tick update and so win on the counter
      if (do_wr) begin
         if (q.waddr == `PFC_OFS_CTRL) begin
            d.mode   = wv[`PFC_CTRL_MODE +: 4];
            d.act[0] = wv[`PFC_CTRL_ACTA +: 2];
            d.act[1] = wv[`PFC_CTRL_ACTB +: 2];
            d.csel   = wv[`PFC_CTRL_CSEL +: 3];
            d.ddr    = wv[`PFC_CTRL_DDR  +: 2];
         end else if (q.waddr == `PFC_OFS_COUNT) begin
            d.cnt = wv[15:0];
         end else if (q.waddr == `PFC_OFS_CMPA) begin
            d.cbuf[0] = wv[15:0];
         end else if (q.waddr == `PFC_OFS_CMPB) begin
            d.cbuf[1] = wv[15:0];
         end else if (q.waddr == `PFC_OFS_CAPTOP) begin
            // Unbuffered: changing it mid-period skews the slopes
            d.icr = wv[15:0];
         end else if (q.waddr == `PFC_OFS_STATUS) begin
            st_clr = q.wstrb[0] ? q.wdata[3:0] : 4'h0;
         end else if (q.waddr == `PFC_OFS_MASK) begin
            d.msk = wv[3:0];
         end
      end

      // Hardware set beats a simultaneous write-one-to-clear
      d.sts = (q.sts & ~st_clr) | st_set;
      d.irq = |(d.sts & d.msk);

      d.awready = (d.wst == PFC_WR_COLLECT) && !d.aw_got;
      d.wready  = (d.wst == PFC_WR_COLLECT) && !d.w_got;

      case (q.rst)
         PFC_RD_IDLE: begin
            if (ar_hs) begin
               d.rst    = PFC_RD_RESP;
               d.rvalid = 1'b1;
               d.rdata  = rd_hit[31:0];
               d.rresp  = rd_hit[32] ? `PFC_RESP_OKAY : `PFC_RESP_SLVERR;
            end
         end
         PFC_RD_RESP: begin
            if (s_axi_rready) begin
               d.rvalid = 1'b0;
               d.rst    = PFC_RD_IDLE;
            end
         end
         default: d.rst = PFC_RD_IDLE;
      endcase
      d.arready = (d.rst == PFC_RD_IDLE);

      // Channel A toggle keeps its pin in modes 9 and 11 but toggles only in 9; B never toggles
      d.oe[0] = d.ddr[0] && (d.act[0] != `PFC_ACT_OFF) &&
                !(d.act[0] == `PFC_ACT_TOGGLE &&
                  d.mode != `PFC_MODE_OCRA &&
                  d.mode != `PFC_MODE_PC_OCRA);
      d.oe[1] = d.ddr[1] && d.act[1][1];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= `PFC_RST_STATE;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready           = q.awready;
   assign s_axi_wready            = q.wready;
   assign s_axi_bvalid            = q.bvalid;
   assign s_axi_bresp             = q.bresp;
   assign s_axi_arready           = q.arready;
   assign s_axi_rvalid            = q.rvalid;
   assign s_axi_rdata             = q.rdata;
   assign s_axi_rresp             = q.rresp;
   assign channel_a_output_pin    = q.oc[0];
   assign channel_a_output_pin_oe = q.oe[0];
   assign channel_b_output_pin    = q.oc[1];
   assign channel_b_output_pin_oe = q.oe[1];
   assign irq                     = q.irq;

endmodule : pfc_timer

// ### tb/pfc_timer_sva.sv
// Purpose: bus handshake and pin ownership checks at the timer ports
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to every timer instance
`timescale 1ns/1ps
`include "pfc_defines.svh"
module pfc_timer_sva (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        channel_a_output_pin_oe,
   input wire logic        channel_b_output_pin_oe,
   input wire logic        irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_wr_bad;
      s_wr_take ##0 (s_axi_awaddr > `PFC_OFS_PINS);
   endsequence
   sequence s_wr_answer;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   AST_RST_QUIET:
      assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid
         && !s_axi_rvalid && !irq && !channel_a_output_pin_oe
         && !channel_b_output_pin_oe) else $error("outputs live in reset");
   AST_WR_WALK:
      assert property (s_wr_take |=> s_wr_answer)
         else $error("write answer late");
   AST_WR_BAD:
      assert property (s_wr_bad |=> s_wr_answer ##0
         (s_axi_bresp == `PFC_RESP_SLVERR)) else $error("bad write okay");
   AST_RD_WALK:
      assert property (s_axi_arvalid && s_axi_arready |=>
         s_axi_rvalid && !s_axi_arready) else $error("read answer late");
   AST_RD_BAD:
      assert property (s_axi_arvalid && s_axi_arready &&
         s_axi_araddr > `PFC_OFS_PINS |=> s_axi_rresp == `PFC_RESP_SLVERR)
         else $error("bad read okay");
   AST_R_DONE:
      assert property (s_axi_rvalid && s_axi_rready |=>
         !s_axi_rvalid && s_axi_arready) else $error("read not retired");
   AST_B_DONE:
      assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
         ##1 (s_axi_awready && s_axi_wready)) else $error("write stuck");
   AST_B_BUSY:
      assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
         else $error("second write taken");
   AST_OE_BY_WRITE:
      assert property ($changed(channel_a_output_pin_oe) ||
         $changed(channel_b_output_pin_oe) |-> s_axi_bvalid)
         else $error("pin ownership moved without a write");
   AST_IRQ_FALL:
      assert property ($fell(irq) |-> s_axi_bvalid)
         else $error("irq dropped without a write");
endmodule : pfc_timer_sva

bind pfc_timer pfc_timer_sva u_sva (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .channel_a_output_pin_oe, .channel_b_output_pin_oe,
   .irq);

// ### tb/pfc_load_model.sv
// Purpose: external load on one compare output pin
// Assumes: pull-down on the board net
// Notes:   a released pin reads low, never the last driven level
`timescale 1ns/1ps
module pfc_load_model (
   input wire logic pin,
   input wire logic oe,
   output logic     pad
);
   assign pad = oe ? pin : 1'b0;
endmodule : pfc_load_model

// ### tb/tb.sv
// Purpose: self-checking bench for the dual-slope PWM timer
// Assumes: aclk 125 MHz, pads pulled low while released
// Notes:   waveforms judged by high time over two whole periods
`timescale 1ns/1ps
`include "pfc_defines.svh"
module tb;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, irq;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [31:0] s_axi_rdata, rd;
   logic        pin_a, pin_b, oe_a, oe_b, pad_a, pad_b;
   int          failures = 0;
   int          n_tests = 0;
   int          seed = 32'h5ADDA181;

   always #4 aclk = ~aclk;

   pfc_timer uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .channel_a_output_pin(pin_a), .channel_a_output_pin_oe(oe_a),
      .channel_b_output_pin(pin_b), .channel_b_output_pin_oe(oe_b), .irq);
   pfc_load_model u_load_a (.pin(pin_a), .oe(oe_a), .pad(pad_a));
   pfc_load_model u_load_b (.pin(pin_b), .oe(oe_b), .pad(pad_b));

   task chk_v(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (e !== g) begin
         failures++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk_v

   task chk_n(input string nm, input int e, input int g);
      n_tests++;
      if (e != g) begin
         failures++;
         $display("BAD %s exp %0d got %0d", nm, e, g);
      end
   endtask : chk_n

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic aw;
      logic w;
      @(posedge aclk);
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end while (!s_axi_bvalid);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task rd_reg(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd_reg

   function int rnd(input int m);
      return $unsigned($random(seed)) % m;
   endfunction : rnd

   // Model of one case: expected pad high cycles over two periods
   task run(input int i);
      int cs, mode, top, ca, cb, acta, actb, ddr, n, p, ha, hb, ea;
      cs = i % 5 + 1;
      mode = (i % 2) ? 9 : 8;
      top = (cs >= 4) ? 3 : 3 + rnd(5);
      cb = (i == 0) ? 0 : (i == 1) ? top : (i == 5) ? top + 1 : rnd(top + 1);
      ca = (mode == 9) ? top : rnd(top + 1);
      acta = rnd(4);
      actb = (i < 4) ? 2 + i % 2 : rnd(4);
      ddr = rnd(4);
      n = (cs == 1) ? 1 : (cs == 2) ? 8 : (cs == 3) ? 64 : (cs == 4) ? 256 : 1024;
      p = 2 * n * top;
      // Freeze first so a smaller top never strands the counter above it
      wr(`PFC_OFS_CTRL, 32'h100);
      wr(`PFC_OFS_COUNT, 32'h0);
      rd_reg(`PFC_OFS_COUNT);
      chk_v("frozen count", 32'h0, rd);
      wr(`PFC_OFS_CMPA, ca);
      wr(`PFC_OFS_CMPB, cb);
      wr(`PFC_OFS_CAPTOP, top);
      wr(`PFC_OFS_CTRL, ddr << 11 | cs << 8 | actb << 6 | acta << 4 | mode);
      repeat (2 * p) @(posedge aclk);
      // Clear after settling: the reload tick still matches old compares
      wr(`PFC_OFS_STATUS, 32'hF);
      ha = 0;
      hb = 0;
      repeat (2 * p) begin
         @(posedge aclk);
         ha += pad_a;
         hb += pad_b;
      end
      rd_reg(`PFC_OFS_COUNT);
      chk_v("count within top", 32'h1, rd <= top);
      chk_v("oe a", (ddr & 1) && (acta >= 2 || acta == 1 && mode == 9), oe_a);
      chk_v("oe b", (ddr >> 1) && actb >= 2, oe_b);
      ea = !(ddr & 1) ? 0 : (acta == 2) ? 4 * n * ca :
           (acta == 3) ? 4 * n * (top - ca) : (acta == 1 && mode == 9) ? p : 0;
      chk_n("high a", ea, ha);
      if (cb <= top) chk_n("high b", !(ddr >> 1) || actb < 2 ? 0 :
         (actb == 2) ? 4 * n * cb : 4 * n * (top - cb), hb);
      rd_reg(`PFC_OFS_STATUS);
      chk_v("status", {mode == 8, cb <= top, mode == 9 || ca <= top, 1'b1},
         rd);
      $display("test %0d done", i);
   endtask : run

   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   initial begin
      #(60000 * 8);
      failures++;
      tally_and_finish;
   end

   initial begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      chk_v("reset pins", 3'h0, {oe_a, oe_b, irq});
      for (int a = 0; a < 36; a += 4) begin
         rd_reg(8'(a));
         if (a < 32) chk_v("reset reg", 32'h0, rd);
         chk_v("read resp", a < 32 ? `PFC_RESP_OKAY : `PFC_RESP_SLVERR, resp);
      end
      wr(8'h24, 32'h1);
      chk_v("bad write resp", `PFC_RESP_SLVERR, resp);
      wr(`PFC_OFS_PINS, 32'hF);
      rd_reg(`PFC_OFS_PINS);
      chk_v("pins read only", 32'h0, rd);
      $display("test reset done");
      for (int i = 0; i < 6; i++) run(i);
      wr(`PFC_OFS_MASK, 32'h1);
      chk_v("irq raised", 1'b1, irq);
      wr(`PFC_OFS_MASK, 32'h0);
      chk_v("irq masked", 1'b0, irq);
      wr(`PFC_OFS_MASK, 32'h1);
      wr(`PFC_OFS_CTRL, 32'h0);
      wr(`PFC_OFS_STATUS, 32'hF);
      chk_v("irq cleared", 1'b0, irq);
      rd_reg(`PFC_OFS_STATUS);
      chk_v("status cleared", 32'h0, rd);
      $display("test irq done");
      tally_and_finish;
   end
endmodule : tb
